// [mdg_selftest.sv]
/*
 * mdg_selftest: self-test sequencer of a synchronous communications
 * controller: power-on internal diagnostic, then host-commanded interface
 * tests driving window registers, interrupt vectors and bus transfers.
 * assumes: master_clr, cmd_valid and the acks are synchronous to mclk;
 * irq_ack and dma_ack are one-cycle pulses answering a held request.
 */
`timescale 1ns/1ps
module mdg_selftest #(
    parameter int HOLD_CYC = mdg_pkg::HOLD_MIN_CYC
) (
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       master_clr,
    input  wire logic                       cmd_valid,
    input  wire logic [2:0]                 cmd_code,
    input  wire logic [mdg_pkg::ADDR_W-1:0] cmd_src,
    input  wire logic [mdg_pkg::ADDR_W-1:0] cmd_dst,
    input  wire logic [mdg_pkg::PASS_W-1:0] cmd_passes,
    output logic                            cmd_ready,
    output logic                            diag_done,
    output logic                            diag_pass,
    output logic [7:0]                      diag_code,
    output logic                            win_we,
    output logic [2:0]                      win_sel,
    output logic [7:0]                      win_data,
    output logic                            irq_req,
    output logic                            irq_vec,
    input  wire logic                       irq_ack,
    output logic                            dma_req,
    output logic                            dma_dir,
    output logic [mdg_pkg::ADDR_W-1:0]      dma_addr,
    output logic [mdg_pkg::DATA_W-1:0]      dma_wdata,
    output logic                            dma_nlt,
    input  wire logic                       dma_ack,
    input  wire logic [mdg_pkg::DATA_W-1:0] dma_rdata,
    output logic                            bus_hold
);

    // ------
    // helpers
    // ------
    localparam logic [mdg_pkg::TMR_W-1:0] HOLD_LAST = mdg_pkg::TMR_W'(HOLD_CYC - 1);

    function automatic logic [7:0] pattern(input logic [1:0] sel);
        case (sel)
            2'h0:    pattern = mdg_pkg::PAT_ONES;
            2'h1:    pattern = mdg_pkg::PAT_ZEROS;
            2'h2:    pattern = mdg_pkg::PAT_ALT_A;
            default: pattern = mdg_pkg::PAT_ALT_B;
        endcase
    endfunction : pattern

    // window bytes in order 0, 2, 3 .. 7; byte one belongs to the host
    function automatic logic [2:0] next_win(input logic [2:0] sel);
        if (sel == mdg_pkg::WIN_FIRST) begin
            next_win = mdg_pkg::WIN_SECOND;
        end else begin
            next_win = sel + 3'h1;
        end
    endfunction : next_win

    // ------
    // state
    // ------
    mdg_pkg::mdg_state_t                st_ff;
    mdg_pkg::mdg_state_t                nxt_st;
    logic                               scr_we;
    logic [mdg_pkg::SCR_W-1:0]          scr_wdata;
    logic [mdg_pkg::SCR_W-1:0]          scr_rdata;

    mdg_scratch u_scratch (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .wr_en      (scr_we),
        .idx        (st_ff.idx),
        .wr_data    (scr_wdata),
        .rd_data_ff (scr_rdata)
    );

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.win_we = 1'b0;
        scr_we        = 1'b0;
        scr_wdata     = pattern(st_ff.pat);

        // hold timer runs from the start of the bus hold test, saturating
        if (st_ff.bus_hold && st_ff.tmr != HOLD_LAST) begin
            nxt_st.tmr = st_ff.tmr + 1'b1;
        end

        case (st_ff.state)
            // ------
            // internal diagnostic
            // ------
            mdg_pkg::S_IN_WR: begin
                scr_we = 1'b1;
                if (st_ff.idx == mdg_pkg::IDX_LAST) begin
                    nxt_st.idx   = '0;
                    nxt_st.state = mdg_pkg::S_IN_RD;
                end else begin
                    nxt_st.idx = st_ff.idx + 1'b1;
                end
            end
            mdg_pkg::S_IN_RD: begin
                nxt_st.state = mdg_pkg::S_IN_CHK;
            end
            mdg_pkg::S_IN_CHK: begin
                if (scr_rdata != pattern(st_ff.pat)) begin
                    // failing pattern and index are folded into the code
                    nxt_st.done  = 1'b1;
                    nxt_st.pass  = 1'b0;
                    nxt_st.code  = mdg_pkg::RES_FAIL_BASE | {3'h0, st_ff.pat, st_ff.idx};
                    nxt_st.state = mdg_pkg::S_FAIL;
                end else if (st_ff.idx != mdg_pkg::IDX_LAST) begin
                    nxt_st.idx   = st_ff.idx + 1'b1;
                    nxt_st.state = mdg_pkg::S_IN_RD;
                end else if (st_ff.pat == mdg_pkg::PAT_LAST) begin
                    nxt_st.done  = 1'b1;
                    nxt_st.pass  = 1'b1;
                    nxt_st.code  = mdg_pkg::RES_PASS;
                    nxt_st.state = mdg_pkg::S_READY;
                end else begin
                    nxt_st.pat   = st_ff.pat + 1'b1;
                    nxt_st.idx   = '0;
                    nxt_st.state = mdg_pkg::S_IN_WR;
                end
            end
            // a failed device stays here until the next master clear
            mdg_pkg::S_FAIL: begin
                nxt_st.state = mdg_pkg::S_FAIL;
            end
            // ------
            // idle: accept one interface test command
            // ------
            mdg_pkg::S_READY: begin
                if (cmd_valid) begin
                    case (cmd_code)
                        mdg_pkg::CMD_WIN_ONES: begin
                            nxt_st.win_sel  = mdg_pkg::WIN_FIRST;
                            nxt_st.win_data = mdg_pkg::WIN_ONES;
                            nxt_st.state    = mdg_pkg::S_WIN;
                        end
                        mdg_pkg::CMD_WIN_ZEROS: begin
                            nxt_st.win_sel  = mdg_pkg::WIN_FIRST;
                            nxt_st.win_data = mdg_pkg::WIN_ZEROS;
                            nxt_st.state    = mdg_pkg::S_WIN;
                        end
                        mdg_pkg::CMD_IRQ_XX0: begin
                            nxt_st.irq_req = 1'b1;
                            nxt_st.irq_vec = mdg_pkg::VEC_XX0;
                            nxt_st.state   = mdg_pkg::S_IRQ;
                        end
                        mdg_pkg::CMD_IRQ_XX4: begin
                            nxt_st.irq_req = 1'b1;
                            nxt_st.irq_vec = mdg_pkg::VEC_XX4;
                            nxt_st.state   = mdg_pkg::S_IRQ;
                        end
                        mdg_pkg::CMD_NPR: begin
                            nxt_st.src    = cmd_src;
                            nxt_st.dst    = cmd_dst;
                            nxt_st.passes = cmd_passes;
                            if (cmd_passes != '0) begin
                                nxt_st.dma_req  = 1'b1;
                                nxt_st.dma_dir  = mdg_pkg::DIR_IN;
                                nxt_st.dma_addr = cmd_src;
                                nxt_st.state    = mdg_pkg::S_NPR_RD;
                            end
                        end
                        mdg_pkg::CMD_HOG: begin
                            nxt_st.src      = cmd_src;
                            nxt_st.cnt      = '0;
                            nxt_st.tmr      = '0;
                            nxt_st.bus_hold = 1'b1;
                            nxt_st.dma_req  = 1'b1;
                            nxt_st.dma_dir  = mdg_pkg::DIR_IN;
                            nxt_st.dma_addr = cmd_src;
                            nxt_st.dma_nlt  = 1'b1;
                            nxt_st.state    = mdg_pkg::S_HOG_RD;
                        end
                        default: begin
                            nxt_st.state = mdg_pkg::S_READY;
                        end
                    endcase
                end
            end
            // ------
            // interface tests; results are left for the host to judge
            // ------
            mdg_pkg::S_WIN: begin
                nxt_st.win_we = 1'b1;
                if (st_ff.win_we) begin
                    if (st_ff.win_sel == mdg_pkg::WIN_LAST) begin
                        nxt_st.win_we = 1'b0;
                        nxt_st.state  = mdg_pkg::S_READY;
                    end else begin
                        nxt_st.win_sel = next_win(st_ff.win_sel);
                    end
                end
            end
            mdg_pkg::S_IRQ: begin
                if (irq_ack) begin
                    nxt_st.irq_req = 1'b0;
                    nxt_st.state   = mdg_pkg::S_READY;
                end
            end
            mdg_pkg::S_NPR_RD: begin
                if (dma_ack) begin
                    nxt_st.dma_wdata = dma_rdata;
                    nxt_st.dma_dir   = mdg_pkg::DIR_OUT;
                    nxt_st.dma_addr  = st_ff.dst;
                    nxt_st.state     = mdg_pkg::S_NPR_WR;
                end
            end
            mdg_pkg::S_NPR_WR: begin
                if (dma_ack) begin
                    nxt_st.passes = st_ff.passes - 1'b1;
                    if (st_ff.passes == mdg_pkg::PASS_W'(1)) begin
                        nxt_st.dma_req = 1'b0;
                        nxt_st.state   = mdg_pkg::S_READY;
                    end else begin
                        nxt_st.dma_dir  = mdg_pkg::DIR_IN;
                        nxt_st.dma_addr = st_ff.src;
                        nxt_st.state    = mdg_pkg::S_NPR_RD;
                    end
                end
            end
            mdg_pkg::S_HOG_RD: begin
                if (dma_ack) begin
                    nxt_st.cnt = st_ff.cnt + 1'b1;
                    if (st_ff.cnt == mdg_pkg::HOG_LAST) begin
                        nxt_st.dma_req = 1'b0;
                        nxt_st.dma_nlt = 1'b0;
                        nxt_st.state   = mdg_pkg::S_HOG_WAIT;
                    end
                end
            end
            // reads may finish early; ownership stays until the least hold time
            mdg_pkg::S_HOG_WAIT: begin
                if (st_ff.tmr == HOLD_LAST) begin
                    nxt_st.bus_hold = 1'b0;
                    nxt_st.irq_req  = 1'b1;
                    nxt_st.irq_vec  = mdg_pkg::VEC_XX0;
                    nxt_st.state    = mdg_pkg::S_IRQ;
                end
            end
            default: begin
                nxt_st = '0;
            end
        endcase

        // master clear drops any test and restarts the internal diagnostic
        if (master_clr) begin
            nxt_st = '0;
        end
    end

    // reset value '0 is S_IN_WR, so the internal test starts on release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------
    // outputs
    // ------
    assign cmd_ready = (st_ff.state == mdg_pkg::S_READY) && !master_clr;
    assign diag_done = st_ff.done;
    assign diag_pass = st_ff.pass;
    assign diag_code = st_ff.code;
    assign win_we    = st_ff.win_we;
    assign win_sel   = st_ff.win_sel;
    assign win_data  = st_ff.win_data;
    assign irq_req   = st_ff.irq_req;
    assign irq_vec   = st_ff.irq_vec;
    assign dma_req   = st_ff.dma_req;
    assign dma_dir   = st_ff.dma_dir;
    assign dma_addr  = st_ff.dma_addr;
    assign dma_wdata = st_ff.dma_wdata;
    assign dma_nlt   = st_ff.dma_nlt;
    assign bus_hold  = st_ff.bus_hold;

endmodule : mdg_selftest

// [mdg_pkg.sv]
/*
 * mdg_pkg: constants, codes, states and state record of the self-test sequencer.
 * assumes: shared by mdg_selftest and mdg_scratch; used as mdg_pkg::name only.
 */
package mdg_pkg;

    // ------
    // internal scratch path under test
    // ------
    localparam int          SCR_DEPTH     = 8;
    localparam int          SCR_W         = 8;
    localparam int          IDX_W         = 3;
    localparam logic [2:0]  IDX_LAST      = 3'h7;
    localparam logic [1:0]  PAT_LAST      = 2'h3;
    localparam logic [7:0]  PAT_ONES      = 8'hff;
    localparam logic [7:0]  PAT_ZEROS     = 8'h00;
    localparam logic [7:0]  PAT_ALT_A     = 8'haa;
    localparam logic [7:0]  PAT_ALT_B     = 8'h55;

    // ------
    // result codes shown to host software
    // ------
    localparam logic [7:0]  RES_NONE      = 8'h00;
    localparam logic [7:0]  RES_PASS      = 8'h01;
    localparam logic [7:0]  RES_FAIL_BASE = 8'h80;

    // ------
    // window registers and vectors
    // ------
    localparam logic [2:0]  WIN_FIRST     = 3'h0;
    localparam logic [2:0]  WIN_SECOND    = 3'h2;
    localparam logic [2:0]  WIN_LAST      = 3'h7;
    localparam logic [7:0]  WIN_ONES      = 8'hff;
    localparam logic [7:0]  WIN_ZEROS     = 8'h00;
    localparam logic        VEC_XX0       = 1'b0;
    localparam logic        VEC_XX4       = 1'b1;
    localparam logic        DIR_IN        = 1'b0;
    localparam logic        DIR_OUT       = 1'b1;

    // ------
    // bus hold test timing
    // ------
    localparam int          HOG_READS     = 256;
    localparam logic [7:0]  HOG_LAST      = 8'(HOG_READS - 1);
    localparam int          CLK_MHZ       = 200;
    localparam int          HOLD_MIN_US   = 100;
    localparam int          HOLD_MIN_CYC  = HOLD_MIN_US * CLK_MHZ;
    localparam int          TMR_W         = 16;
    localparam int          ADDR_W        = 18;
    localparam int          DATA_W        = 16;
    localparam int          PASS_W        = 16;

    typedef enum logic [2:0] {
        CMD_WIN_ONES  = 3'h1,
        CMD_WIN_ZEROS = 3'h2,
        CMD_IRQ_XX0   = 3'h3,
        CMD_IRQ_XX4   = 3'h4,
        CMD_NPR       = 3'h5,
        CMD_HOG       = 3'h6
    } mdg_cmd_t;

    typedef enum logic [3:0] {
        S_IN_WR    = 4'h0,
        S_IN_RD    = 4'h1,
        S_IN_CHK   = 4'h2,
        S_READY    = 4'h3,
        S_FAIL     = 4'h4,
        S_WIN      = 4'h5,
        S_IRQ      = 4'h6,
        S_NPR_RD   = 4'h7,
        S_NPR_WR   = 4'h8,
        S_HOG_RD   = 4'h9,
        S_HOG_WAIT = 4'ha
    } mdg_state_e_t;

    typedef struct packed {
        mdg_state_e_t             state;
        logic [IDX_W-1:0]         idx;
        logic [1:0]               pat;
        logic                     done;
        logic                     pass;
        logic [7:0]               code;
        logic                     win_we;
        logic [2:0]               win_sel;
        logic [7:0]               win_data;
        logic                     irq_req;
        logic                     irq_vec;
        logic                     dma_req;
        logic                     dma_dir;
        logic [ADDR_W-1:0]        dma_addr;
        logic [DATA_W-1:0]        dma_wdata;
        logic                     dma_nlt;
        logic                     bus_hold;
        logic [ADDR_W-1:0]        src;
        logic [ADDR_W-1:0]        dst;
        logic [PASS_W-1:0]        passes;
        logic [7:0]               cnt;
        logic [TMR_W-1:0]         tmr;
    } mdg_state_t;

endpackage : mdg_pkg

// [mdg_scratch.sv]
/*
 * mdg_scratch: small internal register file that the power-on diagnostic
 * writes and reads back to prove the internal data path.
 * assumes: single clock, one write and one registered read per cycle.
 */
`timescale 1ns/1ps
module mdg_scratch #(
    parameter int DEPTH = mdg_pkg::SCR_DEPTH,
    parameter int W     = mdg_pkg::SCR_W,
    parameter int AW    = mdg_pkg::IDX_W
) (
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] idx,
    input  wire logic [W-1:0]  wr_data,
    output logic      [W-1:0]  rd_data_ff
);

    logic [W-1:0] mem [DEPTH];

    // no reset on the array: the diagnostic always writes before it reads
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[idx] <= wr_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= mem[idx];
        end
    end

endmodule : mdg_scratch

// [mdg_selftest_asserts.sv]
/* mdg_selftest_asserts: port-level checks of the self-test sequencer.
   assumes: bound into mdg_selftest; one clock, rst_n async active low. */
`timescale 1ns/1ps
module mdg_selftest_asserts #(
    parameter int HOLD_CYC = mdg_pkg::HOLD_MIN_CYC
) (
    input logic       mclk,
    input logic       rst_n,
    input logic       master_clr,
    input logic       cmd_valid,
    input logic [2:0] cmd_code,
    input logic       cmd_ready,
    input logic       diag_done,
    input logic       diag_pass,
    input logic [7:0] diag_code,
    input logic       win_we,
    input logic [2:0] win_sel,
    input logic [7:0] win_data,
    input logic       irq_req,
    input logic       irq_vec,
    input logic       dma_req,
    input logic       dma_dir,
    input logic       dma_ack,
    input logic       bus_hold
);
    // ------
    // helper counters: reads and cycles of one bus hold
    // ------
    logic [8:0]  hog_ff;
    logic [31:0] hold_ff;
    logic        taken;
    assign taken = cmd_valid && cmd_ready;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hog_ff  <= 9'h000;
            hold_ff <= 32'h0;
        end else begin
            hog_ff  <= bus_hold ? hog_ff + {8'h00, dma_req && dma_ack} : 9'h000;
            hold_ff <= bus_hold ? hold_ff + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ------
    // properties
    // ------
    property p_rdy; cmd_ready |-> diag_done && diag_pass; endproperty
    a_rdy: assert property (p_rdy) else $error("ready before diagnostic pass");
    property p_clr; master_clr |=> !diag_done && !cmd_ready && !win_we && !bus_hold; endproperty
    a_clr: assert property (p_clr) else $error("master clear did not restart");
    property p_res; $rose(diag_done) |-> (diag_pass && diag_code == mdg_pkg::RES_PASS)
        || (!diag_pass && diag_code[7]); endproperty
    a_res: assert property (p_res) else $error("bad diagnostic result");
    property p_idle; cmd_ready && !cmd_valid |=> !win_we && !irq_req && !dma_req && !bus_hold;
    endproperty
    a_idle: assert property (p_idle) else $error("test ran without command");
    property p_quiet; diag_done && !cmd_ready && !master_clr |=> $stable({diag_code, diag_pass});
    endproperty
    a_quiet: assert property (p_quiet) else $error("result changed in a test");
    property p_win1; disable iff (!rst_n || master_clr)
        taken && cmd_code == mdg_pkg::CMD_WIN_ONES |=> ##1 win_we
        && win_sel == mdg_pkg::WIN_FIRST && win_data == mdg_pkg::WIN_ONES
        ##1 win_we && win_sel == mdg_pkg::WIN_SECOND; endproperty
    a_win1: assert property (p_win1) else $error("window ones order");
    property p_win0; disable iff (!rst_n || master_clr)
        taken && cmd_code == mdg_pkg::CMD_WIN_ZEROS |=> ##1
        (win_we && win_data == mdg_pkg::WIN_ZEROS)[*7] ##1 !win_we && cmd_ready; endproperty
    a_win0: assert property (p_win0) else $error("window zeros run");
    property p_irq; taken && (cmd_code == mdg_pkg::CMD_IRQ_XX0 || cmd_code == mdg_pkg::CMD_IRQ_XX4)
        |=> irq_req && irq_vec == ($past(cmd_code) == mdg_pkg::CMD_IRQ_XX4); endproperty
    a_irq: assert property (p_irq) else $error("interrupt vector wrong");
    property p_npr; !master_clr && dma_req && dma_ack && !dma_dir && !bus_hold |=> dma_req
        && dma_dir == mdg_pkg::DIR_OUT; endproperty
    a_npr: assert property (p_npr) else $error("read not followed by write");
    property p_hogrd; bus_hold && dma_req |-> dma_dir == mdg_pkg::DIR_IN; endproperty
    a_hogrd: assert property (p_hogrd) else $error("hold test wrote");
    property p_hog256; $fell(dma_req) && bus_hold |-> hog_ff == 9'h100; endproperty
    a_hog256: assert property (p_hog256) else $error("hold read count");
    property p_hold; $fell(bus_hold) && !$past(master_clr) |-> hold_ff >= HOLD_CYC
        && irq_req && irq_vec == mdg_pkg::VEC_XX0; endproperty
    a_hold: assert property (p_hold) else $error("bus hold short or no interrupt");
    c_hog: cover property ($fell(bus_hold));
    c_npr: cover property (dma_req && dma_ack && dma_dir);
    c_win: cover property (win_we && win_data == mdg_pkg::WIN_ZEROS);
endmodule : mdg_selftest_asserts

bind mdg_selftest mdg_selftest_asserts #(.HOLD_CYC(HOLD_CYC)) i_chk (
    .mclk(mclk), .rst_n(rst_n), .master_clr(master_clr), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ready(cmd_ready), .diag_done(diag_done), .diag_pass(diag_pass),
    .diag_code(diag_code), .win_we(win_we), .win_sel(win_sel), .win_data(win_data),
    .irq_req(irq_req), .irq_vec(irq_vec), .dma_req(dma_req), .dma_dir(dma_dir),
    .dma_ack(dma_ack), .bus_hold(bus_hold));

// [mdg_host_model.sv]
/* mdg_host_model: host side of the sequencer: acks transfers and interrupts.
   assumes: requests are levels held until acked; lat sets the answer delay. */
`timescale 1ns/1ps
module mdg_host_model (
    input  logic                       mclk,
    input  logic                       rst_n,
    input  logic [3:0]                 lat,
    input  logic                       irq_req,
    input  logic                       dma_req,
    input  logic [mdg_pkg::ADDR_W-1:0] dma_addr,
    output logic                       irq_ack,
    output logic                       dma_ack,
    output logic [mdg_pkg::DATA_W-1:0] dma_rdata
);
    logic [3:0] wait_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_ff   <= 4'h0;
            irq_ack   <= 1'b0;
            dma_ack   <= 1'b0;
            dma_rdata <= 16'h0000;
        end else begin
            irq_ack   <= 1'b0;
            dma_ack   <= 1'b0;
            // junk outside an ack
            dma_rdata <= ~dma_rdata;
            if ((dma_req || irq_req) && !dma_ack && !irq_ack) begin
                wait_ff <= wait_ff + 4'h1;
                if (wait_ff >= lat) begin
                    wait_ff   <= 4'h0;
                    dma_ack   <= dma_req;
                    irq_ack   <= irq_req && !dma_req;
                    dma_rdata <= dma_addr[15:0] ^ 16'h3c3c;
                end
            end
        end
    end
endmodule : mdg_host_model

// [mdg_selftest_bench.sv]
/* mdg_selftest_bench: self-checking bench of the self-test sequencer.
   assumes: mdg_host_model answers bus and interrupt requests. */
`timescale 1ns/1ps
module mdg_selftest_bench;
    localparam logic [17:0] SRC = 18'h2_1234;
    localparam logic [17:0] DST = 18'h1_0abc;
    logic        mclk, rst_n, master_clr, cmd_valid, cmd_ready, diag_done, diag_pass;
    logic        win_we, irq_req, irq_vec, irq_ack, dma_req, dma_dir, dma_nlt, dma_ack, bus_hold;
    logic [2:0]  cmd_code, win_sel;
    logic [7:0]  diag_code, win_data;
    logic [17:0] cmd_src, cmd_dst, dma_addr;
    logic [15:0] cmd_passes, dma_wdata, dma_rdata;
    logic [3:0]  lat;
    int          n_mismatch, checks;
    mdg_selftest #(.HOLD_CYC(600)) i_dut (.mclk(mclk), .rst_n(rst_n), .master_clr(master_clr),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_src(cmd_src), .cmd_dst(cmd_dst),
        .cmd_passes(cmd_passes), .cmd_ready(cmd_ready), .diag_done(diag_done),
        .diag_pass(diag_pass), .diag_code(diag_code), .win_we(win_we), .win_sel(win_sel),
        .win_data(win_data), .irq_req(irq_req), .irq_vec(irq_vec), .irq_ack(irq_ack),
        .dma_req(dma_req), .dma_dir(dma_dir), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
        .dma_nlt(dma_nlt), .dma_ack(dma_ack), .dma_rdata(dma_rdata), .bus_hold(bus_hold));
    mdg_host_model i_host (.mclk(mclk), .rst_n(rst_n), .lat(lat), .irq_req(irq_req),
        .dma_req(dma_req), .dma_addr(dma_addr), .irq_ack(irq_ack), .dma_ack(dma_ack),
        .dma_rdata(dma_rdata));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic wait_ready;
        for (int i = 0; i < 2000; i++) begin
            @(negedge mclk);
            if (cmd_ready === 1'b1) return;
        end
        n_mismatch++;
        print_verdict();
    endtask : wait_ready
    task automatic send(input logic [2:0] code, input logic [15:0] n);
        wait_ready();
        @(posedge mclk);
        cmd_valid  <= 1'b1;
        cmd_code   <= code;
        cmd_passes <= n;
        @(posedge mclk);
        cmd_valid  <= 1'b0;
    endtask : send
    // command held since reset must wait for the internal test
    task automatic t_boot;
        int early = 0;
        for (int i = 0; i < 90; i++) begin
            @(negedge mclk);
            early += (cmd_ready !== 1'b0 || irq_req !== 1'b0) ? 1 : 0;
        end
        check("early", early, 0);
        wait_ready();
        check("pass", diag_pass, 1);
        check("code", diag_code, mdg_pkg::RES_PASS);
        @(posedge mclk);
        cmd_valid <= 1'b0;
        @(negedge mclk);
        check("irq", {irq_req, irq_vec}, 2'b10);
    endtask : t_boot
    task automatic t_win(input logic [2:0] code, input logic [7:0] data);
        send(code, 16'h0);
        @(negedge mclk);
        for (int i = 0; i < 7; i++) begin
            @(negedge mclk);
            check("win", {win_we, win_sel, win_data}, {1'b1, 3'(i == 0 ? 0 : i + 1), data});
        end
        @(negedge mclk);
        check("win end", {win_we, cmd_ready}, 2'b01);
    endtask : t_win
    task automatic t_irq(input logic [2:0] code, input logic vec);
        send(code, 16'h0);
        @(negedge mclk);
        check("irq", {irq_req, irq_vec}, {1'b1, vec});
        wait_ready();
        check("irq off", irq_req, 0);
    endtask : t_irq
    task automatic t_npr(input logic [15:0] n);
        int k = 0;
        send(mdg_pkg::CMD_NPR, n);
        for (int i = 0; i < 400; i++) begin
            @(negedge mclk);
            if (dma_req === 1'b1 && dma_ack === 1'b1) begin
                check("move", {dma_dir, dma_addr}, {k[0], k[0] ? DST : SRC});
                if (k[0]) check("wdata", dma_wdata, SRC[15:0] ^ 16'h3c3c);
                k++;
            end
            if (cmd_ready === 1'b1) break;
        end
        check("moves", k, 2 * n);
    endtask : t_npr
    task automatic t_hog;
        int rd = 0, miss = 0, hold = 0, host = 0;
        send(mdg_pkg::CMD_HOG, 16'h0);
        lat <= 4'h0;
        for (int i = 0; i < 1500 && irq_req !== 1'b1; i++) begin
            @(negedge mclk);
            hold += bus_hold ? 1 : 0;
            host += (!bus_hold && !irq_req) ? 1 : 0;
            miss += (dma_ack && dma_req && rd < 255 && !dma_nlt) ? 1 : 0;
            rd   += (dma_ack && dma_req) ? 1 : 0;
        end
        check("reads", rd, 256);
        check("nlt", miss, 0);
        check("hold", hold >= 600, 1);
        check("vec", {irq_req, irq_vec}, 2'b10);
        check("host loop", host < 5, 1);
        wait_ready();
    endtask : t_hog
    task automatic t_clr;
        send(mdg_pkg::CMD_WIN_ONES, 16'h0);
        @(posedge mclk);
        master_clr <= 1'b1;
        @(posedge mclk);
        master_clr <= 1'b0;
        @(negedge mclk);
        check("clr", {win_we, diag_done, cmd_ready}, 3'b000);
        wait_ready();
        check("repass", diag_code, mdg_pkg::RES_PASS);
        send(3'h7, 16'h0);
        @(negedge mclk);
        check("bad code", {win_we, irq_req, dma_req, bus_hold}, 4'h0);
    endtask : t_clr
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        {n_mismatch, checks, rst_n, master_clr, cmd_passes} = '0;
        {cmd_src, cmd_dst, cmd_valid, cmd_code, lat} = {SRC, DST, 1'b1, 3'h3, 4'h5};
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        t_boot();
        t_win(mdg_pkg::CMD_WIN_ONES, mdg_pkg::WIN_ONES);
        t_win(mdg_pkg::CMD_WIN_ZEROS, mdg_pkg::WIN_ZEROS);
        t_irq(mdg_pkg::CMD_IRQ_XX0, mdg_pkg::VEC_XX0);
        t_irq(mdg_pkg::CMD_IRQ_XX4, mdg_pkg::VEC_XX4);
        t_npr(16'h3);
        t_npr(16'h0);
        t_hog();
        t_clr();
        print_verdict();
    end
endmodule : mdg_selftest_bench
